// ==== logic/led_pwm_consts.svh ====
// Constants for the multichannel LED PWM controller.
`ifndef LED_PWM_CONSTS_SVH
`define LED_PWM_CONSTS_SVH
`define CHANNEL_COUNT 36
`define SLAVE_ADDR_HIGH 5'h0f
`define ADDR_SHUTDOWN_CONTROL 8'h00
`define ADDR_CHANNEL_DUTY_FIRST 8'h01
`define ADDR_CHANNEL_DUTY_LAST 8'h24
`define ADDR_SHADOW_UPDATE 8'h25
`define ADDR_CHANNEL_CONTROL_FIRST 8'h26
`define ADDR_CHANNEL_CONTROL_LAST 8'h49
`define ADDR_GLOBAL_LED_DISABLE 8'h4a
`define ADDR_SOFT_RESET_TRIGGER 8'h4f
`define TRIGGER_VALUE 8'h00
`define DEFAULT_BYTE 8'h00
`define DEFAULT_CTRL 3'h0
`define SCALE_FULL 2'h0
`define SCALE_HALF 2'h1
`define SCALE_THIRD 2'h2
`define SCALE_QUARTER 2'h3
`endif

// ==== logic/led_pwm_pkg.sv ====
// Types shared by the multichannel LED PWM controller.
package led_pwm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_REG,
    ST_REG_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_IGNORE
  } serial_state_t;
endpackage

// ==== logic/multichannel_led_pwm_control.sv ====
// Write-only two-wire slave with shadowed per-channel PWM, enable and current scale.
// How it works
// - Two scale bits per channel pick full, half, third or quarter current.
// - Channel enable bit 0 forces that output off, 1 lets it run.
// - Global disable bit 0 set forces all outputs off; resets to 0.
// - Writing zero to the reset register restores every register default.
// - Reset loads all defaults, so no LED is lit.
// - Thirty-six duty registers at consecutive addresses, 256 steps each.
// - Duty value N gives duty step N.
// - Channel control registers ascend, channel 1 at first control address.
// - Shutdown of either kind keeps all register contents.
// - Shutdown bit 0 means software shutdown, 1 means normal running.
// - Software shutdown turns every current source off.
// - Low shutdown pin puts the device in hardware shutdown.
// - Duty and control writes go to shadows until update register gets zero.
// - Only write transfers to address 01111 plus strap bits are answered.
// - Register pointer steps by one after each acknowledged data byte.
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_consts.svh"
module multichannel_led_pwm_control (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_strap,
  input wire logic hw_power_down_n,
  output logic [35:0] led_channel_outputs,
  output logic [71:0] current_scale_sel
);
  localparam int N = `CHANNEL_COUNT;
  logic [2:0] scl_sync_reg, scl_sync_next, sda_sync_reg, sda_sync_next, sdb_sync_reg;
  logic [2:0] sdb_sync_next;
  logic scl_reg, scl_next, sda_reg, sda_next, sdb_reg, sdb_next;
  logic [1:0] strap_reg, strap_next;
  led_pwm_pkg::serial_state_t state_reg, state_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
  logic ack_reg, ack_next;
  logic seen_bits_reg, seen_bits_next;
  logic soft_on_reg, soft_on_next, gdis_reg, gdis_next;
  logic [7:0] duty_sh_reg [N], duty_sh_next [N], duty_reg [N], duty_next [N];
  logic [2:0] ctl_sh_reg [N], ctl_sh_next [N], ctl_reg [N], ctl_next [N];
  logic [7:0] pwm_cnt_reg, pwm_cnt_next;
  logic [35:0] led_next;
  logic [71:0] scale_next;
  logic scl_rise, scl_fall, start_det, stop_det, wr_strobe;
  logic [7:0] wr_addr, wr_data;
  // The pin levels count only when the second and third stages agree.
  always_comb begin
    scl_sync_next = {scl_sync_reg[1:0], scl_in};
    sda_sync_next = {sda_sync_reg[1:0], sda_in};
    sdb_sync_next = {sdb_sync_reg[1:0], hw_power_down_n};
    scl_next = (scl_sync_reg[2] == scl_sync_reg[1]) ? scl_sync_reg[2] : scl_reg;
    sda_next = (sda_sync_reg[2] == sda_sync_reg[1]) ? sda_sync_reg[2] : sda_reg;
    sdb_next = (sdb_sync_reg[2] == sdb_sync_reg[1]) ? sdb_sync_reg[2] : sdb_reg;
    strap_next = addr_strap;
  end
  always_ff @(posedge sys_clk) begin
    scl_sync_reg <= scl_sync_next;
    sda_sync_reg <= sda_sync_next;
    sdb_sync_reg <= sdb_sync_next;
    strap_reg <= strap_next;
    if (!rst_b) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      sdb_reg <= 1'b1;
    end else begin
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      sdb_reg <= sdb_next;
    end
  end
  assign scl_rise = scl_next && !scl_reg;
  assign scl_fall = !scl_next && scl_reg;
  assign start_det = scl_reg && scl_next && sda_reg && !sda_next;
  assign stop_det = scl_reg && scl_next && !sda_reg && sda_next;
  // Serial engine; the strap is sampled every clock so a strap change takes effect one clock later.
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    ack_next = ack_reg;
    wr_strobe = 1'b0;
    wr_addr = ptr_reg;
    wr_data = shift_reg;
    if (start_det) begin
      state_next = led_pwm_pkg::ST_ADDR;
      bit_cnt_next = 3'h0;
      ack_next = 1'b0;
    end else if (stop_det) begin
      state_next = led_pwm_pkg::ST_IDLE;
      ack_next = 1'b0;
    end else begin
      unique case (state_reg)
        led_pwm_pkg::ST_IDLE, led_pwm_pkg::ST_IGNORE: begin
        end
        led_pwm_pkg::ST_ADDR, led_pwm_pkg::ST_REG, led_pwm_pkg::ST_DATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_reg};
            bit_cnt_next = bit_cnt_reg + 3'h1;
          end
          if (scl_fall && bit_cnt_reg == 3'h0 && ack_reg == 1'b0 && seen_bits_reg) begin
            unique case (state_reg)
              led_pwm_pkg::ST_ADDR: begin
                if (shift_reg == {`SLAVE_ADDR_HIGH, strap_reg, 1'b0}) begin
                  state_next = led_pwm_pkg::ST_ADDR_ACK;
                  ack_next = 1'b1;
                end else begin
                  state_next = led_pwm_pkg::ST_IGNORE;
                end
              end
              led_pwm_pkg::ST_REG: begin
                ptr_next = shift_reg;
                state_next = led_pwm_pkg::ST_REG_ACK;
                ack_next = 1'b1;
              end
              led_pwm_pkg::ST_DATA: begin
                wr_strobe = 1'b1;
                ptr_next = ptr_reg + 8'h01;
                state_next = led_pwm_pkg::ST_DATA_ACK;
                ack_next = 1'b1;
              end
            endcase
          end
        end
        led_pwm_pkg::ST_ADDR_ACK, led_pwm_pkg::ST_REG_ACK, led_pwm_pkg::ST_DATA_ACK: begin
          if (scl_fall) begin
            ack_next = 1'b0;
            bit_cnt_next = 3'h0;
            state_next = (state_reg == led_pwm_pkg::ST_ADDR_ACK) ? led_pwm_pkg::ST_REG
                       : led_pwm_pkg::ST_DATA;
          end
        end
      endcase
    end
  end
  // A byte is complete once eight rising edges have been counted and the count wrapped.
  always_comb begin
    seen_bits_next = seen_bits_reg;
    if (start_det || (scl_fall && ack_reg)) begin
      seen_bits_next = 1'b0;
    end else if (scl_rise && bit_cnt_reg == 3'h7) begin
      seen_bits_next = 1'b1;
    end else if (scl_fall && seen_bits_reg) begin
      seen_bits_next = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_reg <= led_pwm_pkg::ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      ack_reg <= 1'b0;
      seen_bits_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      ack_reg <= ack_next;
      seen_bits_reg <= seen_bits_next;
    end
  end
  // Register file; shutdown never touches stored values.
  always_comb begin
    soft_on_next = soft_on_reg;
    gdis_next = gdis_reg;
    duty_sh_next = duty_sh_reg;
    duty_next = duty_reg;
    ctl_sh_next = ctl_sh_reg;
    ctl_next = ctl_reg;
    if (wr_strobe) begin
      if (wr_addr == `ADDR_SHUTDOWN_CONTROL) begin
        soft_on_next = wr_data[0];
      end
      if (wr_addr == `ADDR_GLOBAL_LED_DISABLE) begin
        gdis_next = wr_data[0];
      end
      for (int i = 0; i < N; i++) begin
        if (wr_addr == `ADDR_CHANNEL_DUTY_FIRST + 8'(i)) begin
          duty_sh_next[i] = wr_data;
        end
        if (wr_addr == `ADDR_CHANNEL_CONTROL_FIRST + 8'(i)) begin
          ctl_sh_next[i] = wr_data[2:0];
        end
      end
      if (wr_addr == `ADDR_SHADOW_UPDATE && wr_data == `TRIGGER_VALUE) begin
        duty_next = duty_sh_next;
        ctl_next = ctl_sh_next;
      end
      if (wr_addr == `ADDR_SOFT_RESET_TRIGGER && wr_data == `TRIGGER_VALUE) begin
        soft_on_next = 1'b0;
        gdis_next = 1'b0;
        for (int i = 0; i < N; i++) begin
          duty_sh_next[i] = `DEFAULT_BYTE;
          duty_next[i] = `DEFAULT_BYTE;
          ctl_sh_next[i] = `DEFAULT_CTRL;
          ctl_next[i] = `DEFAULT_CTRL;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      soft_on_reg <= 1'b0;
      gdis_reg <= 1'b0;
      for (int i = 0; i < N; i++) begin
        duty_sh_reg[i] <= `DEFAULT_BYTE;
        duty_reg[i] <= `DEFAULT_BYTE;
        ctl_sh_reg[i] <= `DEFAULT_CTRL;
        ctl_reg[i] <= `DEFAULT_CTRL;
      end
    end else begin
      soft_on_reg <= soft_on_next;
      gdis_reg <= gdis_next;
      duty_sh_reg <= duty_sh_next;
      duty_reg <= duty_next;
      ctl_sh_reg <= ctl_sh_next;
      ctl_reg <= ctl_next;
    end
  end
  // Output stage; the analog current sink reads the scale code directly.
  assign pwm_cnt_next = pwm_cnt_reg + 8'h01;
  generate
    for (genvar g = 0; g < N; g++) begin : g_chan
      assign led_next[g] = (pwm_cnt_reg < duty_reg[g]) && ctl_reg[g][0]
                         && !gdis_reg && soft_on_reg && sdb_reg;
      assign scale_next[2*g+1:2*g] = ctl_reg[g][2:1];
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pwm_cnt_reg <= 8'h00;
      led_channel_outputs <= 36'h0_0000_0000;
      current_scale_sel <= 72'h00_0000_0000_0000_0000;
      sda_out <= 1'b1;
      sda_oe <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_next;
      led_channel_outputs <= led_next;
      current_scale_sel <= scale_next;
      sda_out <= 1'b0;
      sda_oe <= ack_next;
    end
  end
  a_led_off_sdb: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sdb_reg |=> led_channel_outputs == 36'h0_0000_0000) else $error("led on in hw shutdown");
  a_led_off_soft: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !soft_on_reg |=> led_channel_outputs == 36'h0_0000_0000) else $error("led on in sw shutdown");
  a_led_off_gdis: assert property (@(posedge sys_clk) disable iff (!rst_b)
    gdis_reg |=> led_channel_outputs == 36'h0_0000_0000) else $error("led on while disabled");
  a_chan_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctl_reg[0][0] |=> !led_channel_outputs[0]) else $error("disabled channel lit");
  a_duty_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (soft_on_reg && sdb_reg && !gdis_reg && ctl_reg[0][0] && pwm_cnt_reg < duty_reg[0])
    |=> led_channel_outputs[0]) else $error("channel dark below duty");
  a_scale_map: assert property (@(posedge sys_clk) disable iff (!rst_b)
    1'b1 |=> current_scale_sel[1:0] == $past(ctl_reg[0][2:1])) else $error("scale mismatch");
  a_shadow_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(wr_strobe && wr_addr inside {`ADDR_SHADOW_UPDATE, `ADDR_SOFT_RESET_TRIGGER})
    |=> $stable(duty_reg[0])) else $error("duty applied without update");
  a_ptr_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_strobe |=> ptr_reg == $past(ptr_reg) + 8'h01) else $error("pointer not incremented");
  a_soft_reset: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (wr_strobe && wr_addr == `ADDR_SOFT_RESET_TRIGGER && wr_data == `TRIGGER_VALUE)
    |=> !soft_on_reg && duty_reg[0] == 8'h00) else $error("soft reset failed");
  c_addr_ack: cover property (@(posedge sys_clk) state_reg == led_pwm_pkg::ST_ADDR_ACK);
  c_update: cover property (@(posedge sys_clk) wr_strobe && wr_addr == `ADDR_SHADOW_UPDATE);
  c_led_on: cover property (@(posedge sys_clk) led_channel_outputs[0]);
  c_ignore: cover property (@(posedge sys_clk) state_reg == led_pwm_pkg::ST_IGNORE);
endmodule // multichannel_led_pwm_control
`default_nettype wire

// ==== testbench/led_bus_master.sv ====
// Two-wire bus master model that writes bytes to the LED controller.
`timescale 1ns/1ps
`default_nettype none
module led_bus_master (
  input wire logic sys_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Phases last 4 or 8 clocks, above the 2-clock filter minimum once both halves count.
  task automatic start_cond();
    sda_low <= 1'b0;
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= ~b[i];
      tick(4);
      scl <= 1'b1;
      tick(8);
      scl <= 1'b0;
      tick(4);
    end
    // The line is released so the slave alone decides its level.
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    ack = ~sda_wire;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(8);
  endtask
endmodule // led_bus_master
`default_nettype wire

// ==== testbench/multichannel_led_pwm_control_bench.sv ====
// Self-checking bench for the multichannel LED PWM controller.
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_consts.svh"
module multichannel_led_pwm_control_bench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_power_down_n = 1'b1;
  logic [1:0] addr_strap = 2'h2;
  logic scl, sda_low, sda_out, sda_oe, sda_wire, ok;
  logic [35:0] leds;
  logic [71:0] scale;
  int n_errors = 0;
  int n_tests = 0;
  localparam logic [7:0] gamma32 [32] = '{
    8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0a, 8'h0d, 8'h12,
    8'h16, 8'h1c, 8'h21, 8'h27, 8'h2e, 8'h35, 8'h3d, 8'h45,
    8'h4e, 8'h56, 8'h60, 8'h6a, 8'h74, 8'h7e, 8'h8a, 8'h95,
    8'ha1, 8'had, 8'hba, 8'hc7, 8'hd4, 8'he2, 8'hf0, 8'hff};
  always #25 sys_clk = ~sys_clk;
  // The pull-up wins unless some party pulls the line low.
  assign sda_wire = ~(sda_low | (sda_oe & ~sda_out));
  multichannel_led_pwm_control u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
    .hw_power_down_n(hw_power_down_n), .led_channel_outputs(leds), .current_scale_sel(scale));
  led_bus_master u_master (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
  task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic [7:0] ptr, input int n, input logic [7:0] d [4]);
    logic a;
    u_master.start_cond();
    u_master.put_byte({`SLAVE_ADDR_HIGH, addr_strap, 1'b0}, a);
    ok &= a;
    u_master.put_byte(ptr, a);
    ok &= a;
    for (int i = 0; i < n; i++) begin
      u_master.put_byte(d[i], a);
      ok &= a;
    end
    u_master.stop_cond();
  endtask
  // Any 256 consecutive cycles hold exactly one full counter period.
  task automatic duty(input string name, input int ch, input logic [8:0] exp);
    logic [8:0] cnt;
    cnt = 9'h000;
    // Sampling on the falling edge keeps clear of the edge that launches the outputs.
    repeat (256) begin
      @(negedge sys_clk);
      cnt += {8'h00, leds[ch]};
    end
    @(posedge sys_clk);
    check(name, 72'(cnt), 72'(exp));
  endtask
  task automatic t_address();
    logic a;
    u_master.start_cond();
    u_master.put_byte({5'h0e, addr_strap, 1'b0}, a);
    u_master.stop_cond();
    check("ack wrong addr", 72'(a), 72'h0);
    u_master.start_cond();
    u_master.put_byte({`SLAVE_ADDR_HIGH, addr_strap, 1'b1}, a);
    u_master.stop_cond();
    check("ack read", 72'(a), 72'h0);
    $display("address test done");
  endtask
  task automatic t_shadow();
    ok = 1'b1;
    // Duty 255 is the last entry of a gamma table, the brightest breathing step.
    xfer(`ADDR_SHUTDOWN_CONTROL, 4, '{8'h01, 8'h04, 8'h80, 8'hff});
    xfer(`ADDR_CHANNEL_CONTROL_FIRST, 4, '{8'h01, 8'h02, 8'h05, 8'h07});
    xfer(`ADDR_CHANNEL_CONTROL_LAST, 2, '{8'h01, 8'h00, 8'h00, 8'h00});
    duty("shadow duty", 0, 9'h000);
    check("shadow scale", scale, 72'h0);
    xfer(`ADDR_CHANNEL_DUTY_LAST, 2, '{8'h10, 8'h00, 8'h00, 8'h00});
    check("acks", 72'(ok), 72'h1);
    check("scale", scale, 72'h00_0000_0000_0000_00e4);
    duty("duty ch1", 0, 9'h004);
    duty("duty ch2 off", 1, 9'h000);
    duty("duty ch3", 2, 9'h0ff);
    duty("duty ch36", 35, 9'h010);
    $display("shadow test done");
  endtask
  task automatic t_shutdown();
    xfer(`ADDR_GLOBAL_LED_DISABLE, 1, '{8'h01, 8'h00, 8'h00, 8'h00});
    duty("global off", 2, 9'h000);
    xfer(`ADDR_GLOBAL_LED_DISABLE, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
    xfer(`ADDR_SHUTDOWN_CONTROL, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
    duty("soft off", 2, 9'h000);
    xfer(`ADDR_SHUTDOWN_CONTROL, 1, '{8'h01, 8'h00, 8'h00, 8'h00});
    hw_power_down_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    duty("pin off", 2, 9'h000);
    hw_power_down_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    duty("kept duty", 2, 9'h0ff);
    check("kept scale", scale, 72'h00_0000_0000_0000_00e4);
    $display("shutdown test done");
  endtask
  // Channel 36 walks the 32-step gamma table; each duty byte is followed by its update byte.
  task automatic t_breath();
    for (int k = 0; k < 32; k++) begin
      xfer(`ADDR_CHANNEL_DUTY_LAST, 2, '{gamma32[k], 8'h00, 8'h00, 8'h00});
      duty("breath step", 35, {1'b0, gamma32[k]});
    end
    // A nonzero update byte must leave the live duty alone.
    xfer(`ADDR_CHANNEL_DUTY_LAST, 2, '{8'h00, 8'h01, 8'h00, 8'h00});
    duty("update ignored", 35, 9'h0ff);
    $display("breathing test done");
  endtask
  task automatic t_soft_reset();
    xfer(`ADDR_SOFT_RESET_TRIGGER, 1, '{8'h01, 8'h00, 8'h00, 8'h00});
    check("reset ignored", scale, 72'h00_0000_0000_0000_00e4);
    xfer(`ADDR_SOFT_RESET_TRIGGER, 1, '{8'h00, 8'h00, 8'h00, 8'h00});
    check("reset acks", 72'(ok), 72'h1);
    check("reset scale", scale, 72'h0);
    duty("reset duty", 2, 9'h000);
    $display("soft reset test done");
  endtask
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Every scenario together takes about 40000 clocks, so this only trips on a hang.
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    $display("ERROR watchdog expired");
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check("reset leds", 72'(leds), 72'h0);
    check("reset scale", scale, 72'h0);
    $display("reset test done");
    t_address();
    t_shadow();
    t_shutdown();
    t_breath();
    t_soft_reset();
    wrap_up();
  end
endmodule // multichannel_led_pwm_control_bench
`default_nettype wire
